/* tb_top.sv */
/*
  Bench for the video bus time-share block: grant, loads, decode, stall and keys.
  Assumes the display controller model drives line count, blank and refresh.
*/
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] line_cnt;
  logic vblank, refresh_strobe;
  logic [10:0] refresh_addr;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_data_in = 8'h00;
  logic addr_strobe = 1'b0;
  logic cpu_rd = 1'b0;
  logic cpu_wr = 1'b0;
  logic serial_ready = 1'b0;
  logic [7:0] key_sense;
  logic [7:0] keys [8] = '{default: 8'h00};
  logic [7:0] cpu_data_out, video_data, key_drive;
  logic cpu_data_oe, cpu_ready, bus_avail, addr_enable, serial_valid;
  logic rom_sel, keys_sel, serial_sel;
  logic [10:0] top_of_page, row_start, cursor_pos;
  logic [6:0] serial_code;
  int err_total = 0;
  int checked = 0;
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  always_comb
  begin
    key_sense = 8'h00;
    for (int r = 0; r < 8; r++)
      if (key_drive[r] === 1'b1) key_sense = key_sense | keys[r];
  end
  vbt_crt_model model_u (.sys_clk(sys_clk), .resetn(resetn), .line_cnt(line_cnt),
    .vblank(vblank), .refresh_addr(refresh_addr), .refresh_strobe(refresh_strobe));
  vbt_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .line_cnt(line_cnt), .vblank(vblank),
    .refresh_addr(refresh_addr), .refresh_strobe(refresh_strobe), .cpu_addr(cpu_addr),
    .cpu_data_in(cpu_data_in), .addr_strobe(addr_strobe), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .key_sense(key_sense), .serial_ready(serial_ready), .cpu_data_out(cpu_data_out),
    .cpu_data_oe(cpu_data_oe), .cpu_ready(cpu_ready), .bus_avail(bus_avail),
    .addr_enable(addr_enable), .video_data(video_data), .top_of_page(top_of_page),
    .row_start(row_start), .cursor_pos(cursor_pos), .rom_sel(rom_sel), .keys_sel(keys_sel),
    .serial_sel(serial_sel), .key_drive(key_drive), .serial_code(serial_code),
    .serial_valid(serial_valid));
  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic cmp_bit(string name, logic exp, logic got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic cmp_word(string name, logic [10:0] exp, logic [10:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic timeout(string name);
    err_total++;
    $display("mismatch %s expected event seen timeout", name);
    summarize();
  endtask
  task automatic access(logic [1:0] page, logic [11:0] a, logic wr);
    addr_strobe = 1'b1;
    cpu_data_in = {2'b00, page, 4'h0};
    tick();
    addr_strobe = 1'b0;
    cpu_addr = {4'h0, a};
    cpu_rd = !wr;
    cpu_wr = wr;
    tick(4);
  endtask
  task automatic idle;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    tick(4);
  endtask
  task automatic grant_scan;
    logic h [$];
    repeat (400)
    begin
      h.push_back((line_cnt >= 4'h7) || vblank);
      if (h.size() > 4 && h[$-2] == h[$-3] && h[$-3] == h[$-4])
      begin
        cmp_bit("bus_avail", h[$-3], bus_avail);
        cmp_bit("addr_enable", !h[$-3], addr_enable);
      end
      tick();
    end
  endtask
  task automatic load_regs;
    access(2'h1, 12'h7ff, 1'b1);
    idle();
    access(2'h2, 12'h123, 1'b1);
    idle();
    access(2'h3, 12'h456, 1'b1);
    idle();
    access(2'h0, 12'h0aa, 1'b1);
    idle();
    cmp_word("top_of_page", 11'h7ff, top_of_page);
    cmp_word("row_start", 11'h123, row_start);
    cmp_word("cursor_pos", 11'h456, cursor_pos);
  endtask
  task automatic dec_chk(logic [11:0] a, logic rdy, logic [2:0] sel);
    int n = 0;
    while (!(line_cnt == 4'h0 && !vblank))
    begin
      tick();
      n++;
      if (n > 500) timeout("display start");
    end
    access(2'h0, a, 1'b0);
    cmp_bit("cpu_ready", rdy, cpu_ready);
    cmp_bit("cpu_data_oe", 1'b0, cpu_data_oe);
    cmp_word("selects", {8'h00, sel}, {8'h00, rom_sel, keys_sel, serial_sel});
    n = 0;
    while (cpu_ready !== 1'b1)
    begin
      tick();
      n++;
      if (n > 300) timeout("cpu_ready");
    end
    cmp_bit("bus_avail", !rdy, bus_avail);
    cmp_bit("cpu_data_oe", !rdy, cpu_data_oe);
    idle();
  endtask
  task automatic vram_rw(logic [11:0] a, logic [7:0] d);
    int n = 0;
    addr_strobe = 1'b1;
    cpu_data_in = 8'h00;
    tick();
    addr_strobe = 1'b0;
    cpu_addr = {4'h0, a};
    cpu_data_in = d;
    cpu_wr = 1'b1;
    tick(4);
    while (cpu_ready !== 1'b1)
    begin
      tick();
      n++;
      if (n > 300) timeout("write grant");
    end
    cpu_wr = 1'b0;
    cpu_rd = 1'b1;
    tick(4);
    n = 0;
    while (cpu_data_oe !== 1'b1)
    begin
      tick();
      n++;
      if (n > 300) timeout("read grant");
    end
    cmp_word("cpu_data_out", {3'h0, d}, {3'h0, cpu_data_out});
    idle();
  endtask
  task automatic vid_chk(logic [10:0] a, logic [7:0] d);
    int n = 0;
    while (!(refresh_strobe === 1'b1 && refresh_addr === a))
    begin
      tick();
      n++;
      if (n > 6000) timeout("refresh fetch");
    end
    tick(3);
    cmp_word("video_data", {3'h0, d}, {3'h0, video_data});
  endtask
  task automatic key_get(logic [6:0] code);
    int n = 0;
    while (serial_valid !== 1'b1)
    begin
      tick();
      n++;
      if (n > 2000) timeout("serial_valid");
    end
    cmp_word("serial_code", {4'h0, code}, {4'h0, serial_code});
    tick(3);
    cmp_bit("serial_valid", 1'b1, serial_valid);
    serial_ready = 1'b1;
    n = 0;
    while (serial_valid !== 1'b0)
    begin
      tick();
      n++;
      if (n > 50) timeout("serial_valid drop");
    end
    serial_ready = 1'b0;
  endtask
  initial
  begin
    tick(6);
    cmp_word("key_drive", 11'h001, {3'h0, key_drive});
    cmp_bit("addr_enable", 1'b1, addr_enable);
    cmp_bit("cpu_ready", 1'b1, cpu_ready);
    resetn = 1'b1;
    tick(3);
    grant_scan();
    load_regs();
    dec_chk(12'h000, 1'b1, 3'b100);
    dec_chk(12'h200, 1'b1, 3'b010);
    dec_chk(12'h600, 1'b1, 3'b001);
    dec_chk(12'h400, 1'b0, 3'b000);
    dec_chk(12'h800, 1'b0, 3'b000);
    dec_chk(12'he00, 1'b0, 3'b000);
    vram_rw(12'h8a5, 8'h3c);
    vram_rw(12'hc5a, 8'ha5);
    vid_chk(11'h0a5, 8'h3c);
    keys[5] = 8'h08;
    key_get(7'h4b);
    keys[2] = 8'h80;
    key_get(7'h37);
    keys[5] = 8'h00;
    keys[2] = 8'h00;
    keys[7] = 8'h01;
    key_get(7'h58);
    summarize();
  end
endmodule

/* vbt_crt_model.sv */
/*
  Display controller model: scan-line count, vertical blank, refresh address and strobe.
  Assumes the bench clock and reset; each scan line lasts LINE_CYC clocks.
*/
`timescale 1ns/100ps
module vbt_crt_model #(
  parameter int LINE_CYC = 8,
  parameter int ROWS = 2
) (
  input wire logic sys_clk,
  input wire logic resetn,
  output logic [3:0] line_cnt,
  output logic vblank,
  output logic [10:0] refresh_addr,
  output logic refresh_strobe
);
  int cyc_q;
  int row_q;
  assign vblank = (row_q == ROWS);
  assign refresh_strobe = !vblank && (line_cnt < 4'h7);
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cyc_q <= 0;
      row_q <= 0;
      line_cnt <= 4'h0;
      refresh_addr <= 11'h7fc;
    end
    else
    begin
      cyc_q <= #1 (cyc_q == LINE_CYC - 1) ? 0 : cyc_q + 1;
      if (refresh_strobe)
        refresh_addr <= #1 refresh_addr + 11'h001;
      if (cyc_q == LINE_CYC - 1)
      begin
        line_cnt <= #1 (line_cnt == 4'h9) ? 4'h0 : line_cnt + 4'h1;
        if (line_cnt == 4'h9)
          row_q <= #1 (row_q == ROWS) ? 0 : row_q + 1;
      end
    end
  end
endmodule

/* vbt_key_if.sv */
/*
  Interface carrying one key code from the scanner to the top module.
  Assumes both ends share sys_clk.
*/
`timescale 1ns/100ps
interface vbt_key_if;
  logic valid;
  logic ready;
  logic [6:0] code;
  modport src (output valid, output code, input ready);
  modport dst (input valid, input code, output ready);
endinterface

/* vbt_key_scan.sv */
/*
  Keyboard matrix scanner: drives one of eight lines, reads eight sense lines.
  Assumes sense inputs already pass two flip-flops in the top module.
*/
`timescale 1ns/100ps
module vbt_key_scan (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] sense_sync,
  output logic [7:0] drive_q,
  vbt_key_if.src key
);
  vbt_pkg::vbt_key_state_t state_q;
  logic [2:0] row_q;
  logic [63:0] held_q;
  logic [2:0] col_q;
  logic [7:0] new_keys;
  logic any_new;
  logic [2:0] first_col;
  logic [6:0] code_q;
  logic valid_q;
  logic [1:0] settle_q;

  // Only keys not already held count, so a second key while one is held is still seen.
  assign new_keys = sense_sync & ~held_q[row_q*8 +: 8]; // R13
  assign any_new = |new_keys;
  always_comb
  begin
    first_col = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (new_keys[i])
      begin
        first_col = 3'(i);
      end
    end
  end
  assign key.valid = valid_q;
  assign key.code = code_q;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= vbt_pkg::VBT_SCAN;
      row_q <= 3'h0;
      col_q <= 3'h0;
      held_q <= 64'h0000_0000_0000_0000;
      code_q <= 7'h00;
      valid_q <= 1'b0;
      drive_q <= 8'h01;
      settle_q <= 2'h0;
    end
    else
    begin
      unique case (state_q)
        vbt_pkg::VBT_SCAN:
        begin
          if (any_new)
          begin
            col_q <= first_col;
            code_q <= vbt_pkg::KEY_CODE_BASE + 7'({row_q, first_col}); // R12
            valid_q <= 1'b1;
            state_q <= vbt_pkg::VBT_EMIT;
          end
          else
          begin
            held_q[row_q*8 +: 8] <= sense_sync;
            row_q <= row_q + 3'h1; // R11
            drive_q <= {drive_q[6:0], drive_q[7]};
            settle_q <= 2'h0;
            state_q <= vbt_pkg::VBT_WAIT;
          end
        end
        vbt_pkg::VBT_EMIT:
        begin
          if (key.ready)
          begin
            valid_q <= 1'b0;
            held_q[{row_q, col_q}] <= 1'b1;
            state_q <= vbt_pkg::VBT_SCAN;
          end
        end
        vbt_pkg::VBT_WAIT:
        begin
          // The drive output flop and the two sense synchronisers take three clocks to settle.
          settle_q <= settle_q + 2'h1;
          if (settle_q == vbt_pkg::KEY_SETTLE_LAST)
          begin
            state_q <= vbt_pkg::VBT_SCAN; // R12
          end
        end
      endcase
    end
  end

  a_key_code_hold: assert property (@(posedge sys_clk) disable iff (!resetn) // R12
    key.valid && !key.ready |=> key.valid && $stable(key.code))
    else $error("key code dropped before taken");
  a_key_onehot: assert property (@(posedge sys_clk) disable iff (!resetn) // R11
    $onehot(drive_q))
    else $error("keyboard drive not one-hot");
endmodule

/* vbt_pkg.sv */
/*
  Package for the video bus time-share and decode block: page codes, row timing and widths.
  Assumes a single 25 MHz clock domain and no software-visible registers.
*/
package vbt_pkg;
  localparam int unsigned LINES_PER_ROW = 10;
  localparam int unsigned BLANK_LINES = 3;
  localparam logic [3:0] LINE_LAST = 4'h9;
  localparam logic [3:0] LINE_FIRST_BLANK = 4'h7;
  localparam logic [10:0] VRAM_LAST = 11'h7ff;
  localparam int unsigned VRAM_BYTES = 2048;
  localparam int unsigned VRAM_BANKS = 4;
  localparam int unsigned BANK_WORDS = 1024;
  localparam logic [1:0] BIG_PAGE_PERIPH = 2'h0;
  localparam logic [1:0] BIG_PAGE_TOP = 2'h1;
  localparam logic [1:0] BIG_PAGE_ROW = 2'h2;
  localparam logic [1:0] BIG_PAGE_CURSOR = 2'h3;
  localparam logic [2:0] SMALL_PAGE_ROM = 3'h0;
  localparam logic [2:0] SMALL_PAGE_KEYS = 3'h1;
  localparam logic [2:0] SMALL_PAGE_SCRATCH = 3'h2;
  localparam logic [2:0] SMALL_PAGE_SERIAL = 3'h3;
  localparam logic [2:0] SMALL_PAGE_VRAM_LO = 3'h4;
  localparam logic [2:0] SMALL_PAGE_VRAM_HI = 3'h7;
  localparam int unsigned KEY_ROWS = 8;
  localparam int unsigned KEY_COLS = 8;
  localparam logic [6:0] KEY_CODE_BASE = 7'h20;
  localparam logic [2:0] KEY_ROW_LAST = 3'h7;
  localparam logic [1:0] KEY_SETTLE_LAST = 2'h2;
  typedef enum logic [1:0] {VBT_SCAN, VBT_EMIT, VBT_WAIT} vbt_key_state_t;
endpackage

/* vbt_top.sv */
/*
  Video bus time-share and address decode for a minimal CRT terminal.
  Assumes the display controller supplies line count and vertical blank, the processor a
  byte bus with multiplexed high address; all pins enter through two flip-flops.
*/
`timescale 1ns/100ps
// Summary of operation
// R01: The refresh controller owns the video RAM bus through all active display time.
// R02: The processor cannot write video RAM or reach scratch-pad space during display time.
// R03: Program fetches and keyboard scan stay open to the processor at all times.
// R04: A row is ten lines and the processor gets the bus on its three blank lines and in vblank.
// R05: Address bits eleven to nine split memory into equal small pages by plain decode.
// R06: Address bits 12 and 13 taken from the data bus select one of four large pages.
// R07: Large page zero is peripherals and the other three give controller load strobes.
// R08: Those strobes load top-of-page, row-start and cursor registers only.
// R09: Scrolling reloads top-of-page and refresh addressing wraps past the end of video RAM.
// R10: Video RAM is two kilobytes held as four 1024 by 4 banks forming a byte array.
// R11: The scanner covers an eight by eight matrix of 64 keys.
// R12: Scanning runs always and each new key gives one seven-bit code to the serial channel; the scanner here halts in VBT_EMIT until the code is taken.
// R13: Two-key rollover lets a second key held with the first be seen separately.
// R14: Bus-available is the OR of the blank-line count decode and the vertical blank.
// R15: While the processor holds the bus the controller address enable is driven low.
// R16: A video RAM access outside a granted interval is stalled until the next one.
module vbt_top (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] line_cnt,
  input wire logic vblank,
  input wire logic [10:0] refresh_addr,
  input wire logic refresh_strobe,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_data_in,
  input wire logic addr_strobe,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] key_sense,
  input wire logic serial_ready,
  output logic [7:0] cpu_data_out,
  output logic cpu_data_oe,
  output logic cpu_ready,
  output logic bus_avail,
  output logic addr_enable,
  output logic [7:0] video_data,
  output logic [10:0] top_of_page,
  output logic [10:0] row_start,
  output logic [10:0] cursor_pos,
  output logic rom_sel,
  output logic keys_sel,
  output logic serial_sel,
  output logic [7:0] key_drive,
  output logic [6:0] serial_code,
  output logic serial_valid
);
  logic [3:0] line_m_q, line_s_q;
  logic vblank_m_q, vblank_s_q;
  logic [10:0] raddr_m_q, raddr_s_q;
  logic rstb_m_q, rstb_s_q;
  logic [15:0] caddr_m_q, caddr_s_q;
  logic [7:0] cdata_m_q, cdata_s_q;
  logic [4:0] ctl_m_q, ctl_s_q;
  logic [7:0] sense_m_q, sense_s_q;
  logic srdy_m_q, srdy_s_q;
  logic [1:0] big_page_q;
  logic [3:0] bank_nib [vbt_pkg::VRAM_BANKS][vbt_pkg::BANK_WORDS];
  logic [7:0] key_drive_w;
  logic key_ack_q;
  logic [6:0] serial_code_q;
  logic serial_valid_q;
  logic [10:0] fetch_addr;
  logic [10:0] cpu_vaddr;
  logic [2:0] small_page;
  logic blank_line, grant, vram_sel, scratch_sel, rom_w, keys_w, serial_w;
  logic periph_page, vram_req, vram_go, rd_s, wr_s, ctl_load;
  logic [9:0] bank_word;
  logic bank_hi;

  vbt_key_if key_ch ();

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      line_m_q <= 4'h0;
      line_s_q <= 4'h0;
      vblank_m_q <= 1'b0;
      vblank_s_q <= 1'b0;
      raddr_m_q <= 11'h000;
      raddr_s_q <= 11'h000;
      rstb_m_q <= 1'b0;
      rstb_s_q <= 1'b0;
      caddr_m_q <= 16'h0000;
      caddr_s_q <= 16'h0000;
      cdata_m_q <= 8'h00;
      cdata_s_q <= 8'h00;
      ctl_m_q <= 5'h00;
      ctl_s_q <= 5'h00;
      sense_m_q <= 8'h00;
      sense_s_q <= 8'h00;
      srdy_m_q <= 1'b0;
      srdy_s_q <= 1'b0;
    end
    else
    begin
      line_m_q <= line_cnt;
      line_s_q <= line_m_q;
      vblank_m_q <= vblank;
      vblank_s_q <= vblank_m_q;
      raddr_m_q <= refresh_addr;
      raddr_s_q <= raddr_m_q;
      rstb_m_q <= refresh_strobe;
      rstb_s_q <= rstb_m_q;
      caddr_m_q <= cpu_addr;
      caddr_s_q <= caddr_m_q;
      cdata_m_q <= cpu_data_in;
      cdata_s_q <= cdata_m_q;
      ctl_m_q <= {addr_strobe, cpu_rd, cpu_wr, 2'b00};
      ctl_s_q <= ctl_m_q;
      sense_m_q <= key_sense;
      sense_s_q <= sense_m_q;
      srdy_m_q <= serial_ready;
      srdy_s_q <= srdy_m_q;
    end
  end

  assign blank_line = line_s_q >= vbt_pkg::LINE_FIRST_BLANK && line_s_q <= vbt_pkg::LINE_LAST;
  assign grant = blank_line | vblank_s_q; // R14 R04
  assign rd_s = ctl_s_q[3];
  assign wr_s = ctl_s_q[2];
  assign small_page = caddr_s_q[11:9]; // R05
  assign periph_page = big_page_q == vbt_pkg::BIG_PAGE_PERIPH; // R07
  assign rom_w = periph_page && small_page == vbt_pkg::SMALL_PAGE_ROM; // R03
  assign keys_w = periph_page && small_page == vbt_pkg::SMALL_PAGE_KEYS; // R03
  assign scratch_sel = periph_page && small_page == vbt_pkg::SMALL_PAGE_SCRATCH;
  assign serial_w = periph_page && small_page == vbt_pkg::SMALL_PAGE_SERIAL;
  assign vram_sel = periph_page && small_page >= vbt_pkg::SMALL_PAGE_VRAM_LO;
  assign vram_req = (vram_sel | scratch_sel) && (rd_s | wr_s);
  assign vram_go = vram_req && grant; // R02 R16
  assign ctl_load = !periph_page && wr_s; // R07
  assign cpu_vaddr = caddr_s_q[10:0];
  assign fetch_addr = grant ? cpu_vaddr : raddr_s_q; // R01
  // Index arithmetic is 11 bits, so the address past the last byte lands on the first.
  assign bank_word = fetch_addr[9:0]; // R10
  assign bank_hi = fetch_addr[10];

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      big_page_q <= 2'h0;
    end
    else if (ctl_s_q[4])
    begin
      big_page_q <= cdata_s_q[5:4]; // R06
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (vram_go && wr_s)
    begin
      bank_nib[{bank_hi, 1'b0}][bank_word] <= cdata_s_q[3:0]; // R10
      bank_nib[{bank_hi, 1'b1}][bank_word] <= cdata_s_q[7:4];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      top_of_page <= 11'h000;
      row_start <= 11'h000;
      cursor_pos <= 11'h000;
    end
    else if (ctl_load)
    begin
      unique case (big_page_q) // R08
        vbt_pkg::BIG_PAGE_TOP: top_of_page <= caddr_s_q[10:0]; // R09
        vbt_pkg::BIG_PAGE_ROW: row_start <= caddr_s_q[10:0];
        vbt_pkg::BIG_PAGE_CURSOR: cursor_pos <= caddr_s_q[10:0];
        vbt_pkg::BIG_PAGE_PERIPH: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_avail <= 1'b0;
      addr_enable <= 1'b1;
      cpu_ready <= 1'b1;
      cpu_data_out <= 8'h00;
      cpu_data_oe <= 1'b0;
      video_data <= 8'h00;
      rom_sel <= 1'b0;
      keys_sel <= 1'b0;
      serial_sel <= 1'b0;
    end
    else
    begin
      bus_avail <= grant; // R14
      addr_enable <= !grant; // R15
      cpu_ready <= !vram_req || grant; // R16
      cpu_data_out <= {bank_nib[{bank_hi, 1'b1}][bank_word], bank_nib[{bank_hi, 1'b0}][bank_word]};
      cpu_data_oe <= vram_go && rd_s;
      if (!grant && rstb_s_q)
      begin
        video_data <= {bank_nib[{bank_hi, 1'b1}][bank_word], bank_nib[{bank_hi, 1'b0}][bank_word]};
      end
      rom_sel <= rom_w; // R03
      keys_sel <= keys_w;
      serial_sel <= serial_w;
    end
  end

  vbt_key_scan u_scan (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .sense_sync(sense_s_q),
    .drive_q(key_drive_w),
    .key(key_ch.src)
  );

  assign key_ch.ready = key_ack_q;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      key_ack_q <= 1'b0;
      serial_code_q <= 7'h00;
      serial_valid_q <= 1'b0;
      key_drive <= 8'h01;
    end
    else
    begin
      key_drive <= key_drive_w;
      key_ack_q <= 1'b0;
      if (serial_valid_q && srdy_s_q)
      begin
        serial_valid_q <= 1'b0;
      end
      else if (!serial_valid_q && key_ch.valid && !key_ack_q)
      begin
        serial_code_q <= key_ch.code; // R12
        serial_valid_q <= 1'b1;
        key_ack_q <= 1'b1;
      end
    end
  end
  assign serial_code = serial_code_q;
  assign serial_valid = serial_valid_q;

  a_enable_vs_grant: assert property (@(posedge sys_clk) disable iff (!resetn) // R15
    addr_enable == !bus_avail)
    else $error("address enable not opposite of bus grant");
  a_no_vram_display: assert property (@(posedge sys_clk) disable iff (!resetn) // R02
    (vram_req && !grant) |=> !cpu_data_oe)
    else $error("processor reached video RAM during display");
  a_stall_outside: assert property (@(posedge sys_clk) disable iff (!resetn) // R16
    (vram_req && !grant) |=> !cpu_ready)
    else $error("video RAM access not stalled");
  a_grant_vblank: assert property (@(posedge sys_clk) disable iff (!resetn) // R04
    vblank_s_q |=> bus_avail)
    else $error("no grant during vertical blank");
  a_rom_always: assert property (@(posedge sys_clk) disable iff (!resetn) // R03
    rom_w |=> rom_sel)
    else $error("program fetch blocked");
  a_top_load: assert property (@(posedge sys_clk) disable iff (!resetn) // R09
    ctl_load && big_page_q == vbt_pkg::BIG_PAGE_TOP |=> top_of_page == $past(caddr_s_q[10:0]))
    else $error("top of page not loaded");
  a_periph_no_load: assert property (@(posedge sys_clk) disable iff (!resetn) // R07
    periph_page |=> $stable(cursor_pos))
    else $error("peripheral page loaded controller");
  a_key_forward: assert property (@(posedge sys_clk) disable iff (!resetn) // R12
    serial_valid_q && !srdy_s_q |=> serial_valid_q && $stable(serial_code_q))
    else $error("serial code lost");

  // A stalled video RAM access waits for the grant and then completes.
  sequence s_vram_stalled;
    vram_req && !grant;
  endsequence
  sequence s_vram_granted;
    vram_req && grant;
  endsequence
  a_stall_release: assert property (@(posedge sys_clk) disable iff (!resetn) // R16
    s_vram_stalled ##1 s_vram_granted |=> cpu_ready && (cpu_data_oe == $past(rd_s)))
    else $error("stalled access not released on grant");
  a_row_load: assert property (@(posedge sys_clk) disable iff (!resetn) // R08
    ctl_load && big_page_q == vbt_pkg::BIG_PAGE_ROW
    |=> row_start == $past(caddr_s_q[10:0]))
    else $error("row start not loaded");
  a_cursor_load: assert property (@(posedge sys_clk) disable iff (!resetn) // R08
    ctl_load && big_page_q == vbt_pkg::BIG_PAGE_CURSOR
    |=> cursor_pos == $past(caddr_s_q[10:0]))
    else $error("cursor not loaded");
  a_grant_blank: assert property (@(posedge sys_clk) disable iff (!resetn) // R04
    blank_line |=> bus_avail)
    else $error("no grant on blank scan line");
  a_refresh_owns: assert property (@(posedge sys_clk) disable iff (!resetn) // R01
    !grant |=> addr_enable)
    else $error("refresh lost the bus during display");
  a_ack_single: assert property (@(posedge sys_clk) disable iff (!resetn) // R12
    key_ack_q |=> !key_ack_q)
    else $error("key taken twice");
  a_oe_granted: assert property (@(posedge sys_clk) disable iff (!resetn) // R02
    cpu_data_oe |-> bus_avail)
    else $error("processor drove video data without grant");
endmodule
